// file: tb_tx_serial_config_mode_control.sv
// Self-checking bench joining host and transmitter ends over the link
`timescale 1ns/1ns
`default_nettype none
module tb_tx_serial_config_mode_control
  import txcfg_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, config_word, wire_word;
  logic config_valid, clk_only_select, vco_band_select, clock_divider_select;
  logic modulation_select, clock_output_enable, crystal_oscillator, pll_on, pa_on;
  logic clock_output_driver, clock_out, tx_modulation, rf_ask_key, sclk_q;
  logic [14:0] carrier_frequency_word;
  logic [7:0] fsk_deviation_word;
  logic [3:0] pa_power_level;
  txcfg_mode_t mode;
  int num_errors = 0;
  int checked = 0;
  int wire_cnt = 0;
  int out_per = 0;
  int out_t = 0;
  int unsigned exp_q[$];
  txcfg_link_if link();
  txcfg_host u_txcfg_host (.clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .link(link));
  // Short start-up and lock counts keep the run brief
  txcfg_device #(.XTO_START_CYCLES(4), .PLL_LOCK_CYCLES(2)) u_txcfg_device (.clock(clock),
    .reset_n(reset_n), .link(link), .config_word(config_word), .config_valid(config_valid),
    .clk_only_select(clk_only_select), .vco_band_select(vco_band_select),
    .carrier_frequency_word(carrier_frequency_word), .fsk_deviation_word(fsk_deviation_word),
    .clock_divider_select(clock_divider_select), .pa_power_level(pa_power_level),
    .modulation_select(modulation_select), .clock_output_enable(clock_output_enable),
    .mode(mode), .crystal_oscillator(crystal_oscillator), .pll_on(pll_on), .pa_on(pa_on),
    .clock_output_driver(clock_output_driver), .clock_out(clock_out),
    .tx_modulation(tx_modulation), .rf_ask_key(rf_ask_key));
  txcfg_link_checker u_txcfg_link_checker (.clock(clock), .reset_n(reset_n),
    .enable(link.enable), .sclk(link.sclk),
    .serial_data_modulation_in(link.serial_data_modulation_in), .mode(mode),
    .config_word(config_word), .config_valid(config_valid),
    .clock_output_enable(clock_output_enable),
    .crystal_oscillator(crystal_oscillator), .pll_on(pll_on), .pa_on(pa_on),
    .clock_output_driver(clock_output_driver));
  // ----------------------------------------------------------------
  // Clock, wire capture and divider period
  // ----------------------------------------------------------------
  always #50 clock = ~clock;
  always @(posedge clock)
  begin
    sclk_q <= link.sclk;
    if (!link.enable)
      wire_cnt <= 0;
    else if (link.sclk && !sclk_q)
    begin
      wire_word <= {wire_word[30:0], link.serial_data_modulation_in};
      wire_cnt <= wire_cnt + 1;
    end
  end
  always @(posedge clock_out)
  begin
    out_per <= (int'($time) - out_t) / CLK_PERIOD_NS;
    out_t <= int'($time);
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic wait_mode(input txcfg_mode_t m);
    for (int i = 0; i < 300 && mode !== m; i++)
      @(posedge clock);
    #1;
    chk(mode, m, "mode");
  endtask
  task automatic settle();
    logic [31:0] v = 32'h0000_0000;
    int unsigned e;
    e = exp_q[$];
    for (int i = 0; i < 300 && v[STAT_PROGRAMMED] !== 1'b1; i++)
      rd_reg(HREG_STATUS, v);
    repeat (4) @(posedge clock);
    #1;
    chk(wire_cnt, 32, "bit count");
    chk(wire_word, e, "wire order");
    chk(config_word, e, "word");
    chk(config_valid, 1, "valid");
    chk(clk_only_select, e[31], "clock only");
    chk(vco_band_select, e[30], "band");
    chk(carrier_frequency_word, (e >> 15) & 32'h0000_7FFF, "carrier_frequency_word");
    chk(fsk_deviation_word, (e >> 7) & 32'h0000_00FF, "dev");
    chk(clock_divider_select, e[6], "div");
    chk(pa_power_level, (e >> 2) & 32'h0000_000F, "power");
    chk(modulation_select, e[1], "mod");
    chk(clock_output_enable, e[0], "clk en");
    wait_mode(e[31] ? TXCFG_CLK_ONLY : transmit_with_pa_state);
    chk(pa_on, !e[31], "pa");
    chk(pll_on, !e[31], "pll");
    chk(clock_output_driver, e[0], "driver");
    repeat (30) @(posedge clock);
    if (e[0])
      chk(out_per, e[6] ? 4 : 8, "divider");
    else
      chk(clock_out, 0, "clock idle");
    // Data pin now carries modulation: walk it high then low
    for (int b = 1; b >= 0; b--)
    begin
      wr_reg(HREG_CTRL, b << CTRL_TX_DATA);
      repeat (3) @(posedge clock);
      #1;
      chk(tx_modulation, b, "tx level");
      chk(rf_ask_key, !e[31] && (!e[1] || b), "rf key");
    end
  endtask
  task automatic power_down();
    wr_reg(HREG_CTRL, 32'h0000_0002);
    wait_mode(TXCFG_OFF);
    chk(crystal_oscillator, 0, "xto off");
    chk(config_valid, 0, "valid cleared");
  endtask
  task automatic prog(input logic [31:0] w, input bit pd);
    logic [31:0] v;
    exp_q.push_back(w);
    wr_reg(HREG_CFG, w);
    rd_reg(HREG_CFG, v);
    chk(v, w, "cfg readback");
    wr_reg(HREG_CTRL, 32'h0000_0001);
    settle();
    if (pd)
      power_down();
    $display("test program %h done", w);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end
  initial
  begin
    logic [31:0] v;
    void'($urandom(51824));
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    rd_reg(HREG_STATUS, v);
    chk(v, 0, "status after reset");
    chk(mode, TXCFG_OFF, "mode after reset");
    rd_reg(4'hC, v);
    chk(v, 0, "unmapped read");
    $display("test reset done");
    prog(32'h7FFF_FFFF, 1'b1);
    prog(32'h0000_0001, 1'b1);
    prog(32'h8000_0041, 1'b1);
    for (int i = 0; i < 2; i++)
      prog({1'b0, 31'($urandom)}, 1'b1);
    prog(32'h4123_4567, 1'b0);
    // Hold mode resends the stored word with the oscillator kept running
    wr_reg(HREG_CTRL, 32'h0000_0004);
    wait_mode(TXCFG_RESET_REG);
    chk(crystal_oscillator, 1, "hold xto");
    chk(pll_on | pa_on, 0, "hold pll pa");
    exp_q.push_back(exp_q[$]);
    settle();
    power_down();
    $display("test reprogram done");
    wrap_up();
  end
endmodule // tb_tx_serial_config_mode_control
`default_nettype wire

// file: txcfg_device.sv
// Transmitter end: serial configuration capture and operating mode control
`timescale 1ns/1ns
`default_nettype none
module txcfg_device
  import txcfg_pkg::*;
#(
  parameter int XTO_START_CYCLES = XTO_START_DEF,
  parameter int PLL_LOCK_CYCLES = PLL_LOCK_DEF
)
(
  input wire logic clock,
  input wire logic reset_n,
  txcfg_link_if.dev link,
  output logic [31:0] config_word,
  output logic config_valid,
  output logic clk_only_select,
  output logic vco_band_select,
  output logic [14:0] carrier_frequency_word,
  output logic [7:0] fsk_deviation_word,
  output logic clock_divider_select,
  output logic [3:0] pa_power_level,
  output logic modulation_select,
  output logic clock_output_enable,
  output txcfg_mode_t mode,
  output logic crystal_oscillator,
  output logic pll_on,
  output logic pa_on,
  output logic clock_output_driver,
  output logic clock_out,
  output logic tx_modulation,
  output logic rf_ask_key
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    txcfg_mode_t mode;
    logic [31:0] shift;
    logic [5:0] cnt;
    logic done;
    logic [31:0] cfg;
    logic sclk_q;
    logic [15:0] xto_cnt;
    logic xto_rdy;
    logic [15:0] lock_cnt;
    logic [7:0] hold_cnt;
    logic [2:0] div;
    logic clk_o;
    logic tx_mod;
  } txcfg_dev_state_t;

  txcfg_dev_state_t s_r;
  txcfg_dev_state_t s_nxt;

  function automatic logic drv_mode(input txcfg_mode_t m);
    drv_mode = (m == TXCFG_TX1) || (m == transmit_with_pa_state) || (m == TXCFG_CLK_ONLY) ||
               (m == TXCFG_RESET_REG) || (m == TXCFG_CONFIG1) || (m == TXCFG_CONFIG2);
  endfunction

  logic en;
  logic sd;
  logic sck_rise;
  logic sck_fall;
  logic hold_met;
  logic drv_on;

  assign en = link.enable;
  assign sd = link.serial_data_modulation_in;
  assign sck_rise = link.sclk & ~s_r.sclk_q;
  assign sck_fall = ~link.sclk & s_r.sclk_q;
  // Count already holds the cycles before this one, so this is the last one
  assign hold_met = (s_r.hold_cnt >= 8'(RESET_MIN_CYC - 1));
  assign drv_on = drv_mode(s_r.mode) & s_r.cfg[BIT_CLK_ON];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sclk_q = link.sclk;
    // Serial capture
    if (!en)
    begin
      s_nxt.cnt = 6'h00;
      s_nxt.done = 1'b0;
    end
    else if (!s_r.done && (s_r.mode != TXCFG_OFF) && (s_r.mode != TXCFG_RESET_REG))
    begin
      // Gating on done drops every later clock edge
      if (sck_rise && (s_r.cnt < CFG_BITS_CNT))
      begin
        s_nxt.shift = {s_r.shift[30:0], sd};
        s_nxt.cnt = s_r.cnt + 6'h01;
      end
      else if (sck_fall && (s_r.cnt == CFG_BITS_CNT))
      begin
        s_nxt.cfg = s_r.shift;
        s_nxt.done = 1'b1;
      end
    end
    // Data pin only reaches the modulator after a full word
    s_nxt.tx_mod = s_r.done & en & sd;
    // Oscillator start-up, stopped only in the off mode
    if (s_r.mode == TXCFG_OFF)
    begin
      s_nxt.xto_cnt = 16'h0000;
      s_nxt.xto_rdy = 1'b0;
    end
    else if (!s_r.xto_rdy)
    begin
      s_nxt.xto_cnt = s_r.xto_cnt + 16'h0001;
      s_nxt.xto_rdy = (s_r.xto_cnt >= 16'(XTO_START_CYCLES - 1));
    end
    // Reprogram-hold qualification
    if (!en && sd)
    begin
      if (!hold_met)
      begin
        s_nxt.hold_cnt = s_r.hold_cnt + 8'h01;
      end
    end
    else
    begin
      s_nxt.hold_cnt = 8'h00;
    end
    // Mode sequencing
    case (s_r.mode)
      TXCFG_OFF:
      begin
        if (en)
        begin
          s_nxt.mode = TXCFG_STARTUP1;
        end
      end
      TXCFG_STARTUP1:
      begin
        if (s_r.xto_rdy)
        begin
          s_nxt.mode = TXCFG_STARTUP2;
        end
      end
      TXCFG_STARTUP2, TXCFG_CONFIG1:
      begin
        if (s_r.done && s_r.cfg[BIT_CLK_ONLY])
        begin
          s_nxt.mode = TXCFG_CLK_ONLY;
        end
        else if (s_r.done)
        begin
          s_nxt.mode = (s_r.mode == TXCFG_STARTUP2) ? TXCFG_TX1 : TXCFG_CONFIG2;
          s_nxt.lock_cnt = 16'h0000;
        end
      end
      TXCFG_TX1, TXCFG_CONFIG2:
      begin
        // PA waits for the loop to settle
        s_nxt.lock_cnt = s_r.lock_cnt + 16'h0001;
        if (s_r.lock_cnt >= 16'(PLL_LOCK_CYCLES - 1))
        begin
          s_nxt.mode = transmit_with_pa_state;
        end
      end
      TXCFG_RESET_REG:
      begin
        if (en)
        begin
          s_nxt.mode = TXCFG_CONFIG1;
        end
      end
      transmit_with_pa_state, TXCFG_CLK_ONLY:
      begin
        s_nxt.mode = s_r.mode;
      end
      default:
      begin
        s_nxt.mode = TXCFG_OFF;
      end
    endcase
    // Enable low with data low, or with a qualified hold, overrides the sequence above
    if (!en && !sd)
    begin
      s_nxt.mode = TXCFG_OFF;
    end
    else if (!en && hold_met && (s_r.mode != TXCFG_OFF))
    begin
      s_nxt.mode = TXCFG_RESET_REG;
    end
    // Clock output divider
    s_nxt.div = drv_on ? (s_r.div + 3'h1) : 3'h0;
    s_nxt.clk_o = drv_on & (s_r.cfg[BIT_DIV_SEL] ? s_r.div[1] : s_r.div[2]);
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Decoded configuration
  // ----------------------------------------------------------------
  assign config_word = s_r.cfg;
  assign config_valid = s_r.done;
  assign clk_only_select = s_r.cfg[BIT_CLK_ONLY];
  assign vco_band_select = s_r.cfg[BIT_VCO_BAND];
  assign carrier_frequency_word = s_r.cfg[CARRIER_FREQUENCY_WORD_LSB +: CARRIER_FREQUENCY_WORD_W];
  assign fsk_deviation_word = s_r.cfg[FSK_DEVIATION_WORD_LSB +: FSK_DEVIATION_WORD_W];
  assign clock_divider_select = s_r.cfg[BIT_DIV_SEL];
  assign pa_power_level = s_r.cfg[PWR_LSB +: PWR_W];
  assign modulation_select = s_r.cfg[BIT_MOD_SEL];
  assign clock_output_enable = s_r.cfg[BIT_CLK_ON];

  // ----------------------------------------------------------------
  // Block activity
  // ----------------------------------------------------------------
  assign mode = s_r.mode;
  assign crystal_oscillator = (s_r.mode != TXCFG_OFF);
  assign pll_on = (s_r.mode == TXCFG_STARTUP2) || (s_r.mode == TXCFG_TX1) ||
                  (s_r.mode == transmit_with_pa_state) || (s_r.mode == TXCFG_CONFIG2);
  assign pa_on = (s_r.mode == transmit_with_pa_state);
  assign clock_output_driver = drv_on;
  assign clock_out = s_r.clk_o;
  assign tx_modulation = s_r.tx_mod;
  // In FSK the PA stays on and the loop shifts frequency instead
  assign rf_ask_key = pa_on & (s_r.cfg[BIT_MOD_SEL] ? s_r.tx_mod : 1'b1);

endmodule // txcfg_device
`default_nettype wire

// file: txcfg_host.sv
// Host end: register-driven sequencer for the three-wire configuration link
`timescale 1ns/1ns
`default_nettype none
module txcfg_host
  import txcfg_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  txcfg_link_if.host link
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    txcfg_hstate_t st;
    logic [31:0] cfg;
    logic txd;
    logic [5:0] cnt;
    logic [7:0] tmr;
    logic en;
    logic sck;
    logic sd;
    logic done;
    logic [31:0] rdata;
  } txcfg_host_state_t;

  txcfg_host_state_t h_r;
  txcfg_host_state_t h_nxt;

  function automatic logic [7:0] wait_cyc(input int cyc);
    wait_cyc = 8'(cyc - 1);
  endfunction

  always_comb
  begin
    h_nxt = h_r;
    h_nxt.rdata = 32'h0000_0000;
    if (h_r.tmr != 8'h00)
    begin
      h_nxt.tmr = h_r.tmr - 8'h01;
    end
    case (h_r.st)
      TXCFG_H_LEAD:
      begin
        if (h_r.tmr == 8'h00)
        begin
          h_nxt.st = TXCFG_H_SHIFT_LO;
          h_nxt.sd = h_r.cfg[5'd31 - h_r.cnt[4:0]];
          h_nxt.tmr = wait_cyc(SCK_HALF_CYC);
        end
      end
      TXCFG_H_SHIFT_LO:
      begin
        if (h_r.tmr == 8'h00)
        begin
          h_nxt.st = TXCFG_H_SHIFT_HI;
          h_nxt.sck = 1'b1;
          h_nxt.tmr = wait_cyc(SCK_HALF_CYC);
        end
      end
      TXCFG_H_SHIFT_HI:
      begin
        if (h_r.tmr == 8'h00)
        begin
          h_nxt.sck = 1'b0;
          h_nxt.cnt = h_r.cnt + 6'h01;
          h_nxt.tmr = wait_cyc(SCK_HALF_CYC);
          if (h_r.cnt == CFG_BITS_CNT - 6'h01)
          begin
            h_nxt.st = TXCFG_H_XMIT;
            h_nxt.done = 1'b1;
            h_nxt.sd = h_r.txd;
          end
          else
          begin
            h_nxt.st = TXCFG_H_SHIFT_LO;
            h_nxt.sd = h_r.cfg[5'd30 - h_r.cnt[4:0]];
          end
        end
      end
      TXCFG_H_XMIT:
      begin
        h_nxt.sd = h_r.txd;
      end
      TXCFG_H_RH_HOLD:
      begin
        if (h_r.tmr == 8'h00)
        begin
          h_nxt.st = TXCFG_H_RH_EN;
          h_nxt.en = 1'b1;
          h_nxt.sd = 1'b0;
          h_nxt.tmr = wait_cyc(RESET_MIN_CYC);
        end
      end
      TXCFG_H_RH_EN:
      begin
        if (h_r.tmr == 8'h00)
        begin
          h_nxt.st = TXCFG_H_LEAD;
          h_nxt.sd = 1'b1;
          h_nxt.tmr = wait_cyc(SCK_HALF_CYC);
        end
      end
      TXCFG_H_OFF:
      begin
        h_nxt.st = TXCFG_H_OFF;
      end
      default:
      begin
        h_nxt.st = TXCFG_H_OFF;
      end
    endcase
    // Register writes; a write wins over the sequencer in its cycle
    if (wr && (addr == HREG_CFG) && (h_r.st == TXCFG_H_OFF))
    begin
      h_nxt.cfg = wdata;
    end
    if (wr && (addr == HREG_CTRL))
    begin
      h_nxt.txd = wdata[CTRL_TX_DATA];
      if (wdata[CTRL_POWER_DOWN])
      begin
        h_nxt = '{st: TXCFG_H_OFF, cfg: h_r.cfg, txd: wdata[CTRL_TX_DATA], cnt: 6'h00,
                  tmr: 8'h00, en: 1'b0, sck: 1'b0, sd: 1'b0, done: 1'b0,
                  rdata: 32'h0000_0000};
      end
      else if (wdata[CTRL_PROGRAM] && (h_r.st == TXCFG_H_OFF))
      begin
        h_nxt.st = TXCFG_H_LEAD;
        h_nxt.en = 1'b1;
        h_nxt.cnt = 6'h00;
        h_nxt.tmr = wait_cyc(SCK_HALF_CYC);
      end
      else if (wdata[CTRL_REPROGRAM] && (h_r.st == TXCFG_H_XMIT))
      begin
        h_nxt.st = TXCFG_H_RH_HOLD;
        h_nxt.en = 1'b0;
        h_nxt.sd = 1'b1;
        h_nxt.sck = 1'b0;
        h_nxt.done = 1'b0;
        h_nxt.cnt = 6'h00;
        // Qualify time plus the minimum stay in hold, with margin
        h_nxt.tmr = wait_cyc(2 * RESET_MIN_CYC + SCK_HALF_CYC);
      end
    end
    if (rd)
    begin
      case (addr)
        HREG_CFG: h_nxt.rdata = h_r.cfg;
        HREG_CTRL: h_nxt.rdata = 32'(h_r.txd) << CTRL_TX_DATA;
        HREG_STATUS: h_nxt.rdata = {28'h000_0000, h_r.txd, 1'b0, h_r.done,
                                    (h_r.st != TXCFG_H_OFF) && (h_r.st != TXCFG_H_XMIT)};
        default: h_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      h_r <= '0;
    end
    else
    begin
      h_r <= h_nxt;
    end
  end

  assign rdata = h_r.rdata;
  assign link.enable = h_r.en;
  assign link.sclk = h_r.sck;
  assign link.serial_data_modulation_in = h_r.sd;

endmodule // txcfg_host
`default_nettype wire

// file: txcfg_link_checker.sv
// Assertion checker for the configuration link and transmitter activity
`timescale 1ns/1ns
`default_nettype none
module txcfg_link_checker
  import txcfg_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic sclk,
  input wire logic serial_data_modulation_in,
  input wire txcfg_mode_t mode,
  input wire logic config_valid,
  input wire logic [31:0] config_word,
  input wire logic clock_output_enable,
  input wire logic crystal_oscillator,
  input wire logic pll_on,
  input wire logic pa_on,
  input wire logic clock_output_driver
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------
  // Wire timing
  // ----------------------------------------------------------------
  sclk_high_hold_a: assert property ($rose(sclk) |=> sclk[*2])
    else $error("serial clock high phase too short");
  data_stable_high_a: assert property (sclk |-> $stable(serial_data_modulation_in))
    else $error("data moved while serial clock high");
  enable_first_a: assert property ($rose(enable) |-> !serial_data_modulation_in)
    else $error("data high as enable rose");
  // Hold must last its minimum after the device has qualified it
  hold_stay_a: assert property ($rose(mode == TXCFG_RESET_REG) |-> ##99
    mode == TXCFG_RESET_REG)
    else $error("hold mode left too early");
  // ----------------------------------------------------------------
  // Modes and activity
  // ----------------------------------------------------------------
  // Two cycles allowed, though the device decodes the lines unregistered and is off one cycle later
  power_down_a: assert property (!enable && !serial_data_modulation_in
    |-> ##[1:2] mode == TXCFG_OFF)
    else $error("no power down");
  valid_drop_a: assert property (!enable |-> ##[1:3] !config_valid)
    else $error("word still valid with enable low");
  // Late serial clocks must not disturb a committed word
  word_frozen_a: assert property (config_valid |=>
    !config_valid || $stable(config_word))
    else $error("committed word changed");
  pa_mode_only_a: assert property (pa_on |-> mode == transmit_with_pa_state)
    else $error("amplifier on outside its mode");
  pll_mode_only_a: assert property (pll_on |-> mode inside {TXCFG_STARTUP2,
    TXCFG_TX1, transmit_with_pa_state, TXCFG_CONFIG2})
    else $error("synthesiser on outside its modes");
  off_all_idle_a: assert property (mode == TXCFG_OFF |->
    !crystal_oscillator && !pll_on && !pa_on && !clock_output_driver)
    else $error("block active while off");
  hold_xto_only_a: assert property (mode == TXCFG_RESET_REG |->
    crystal_oscillator && !pll_on && !pa_on)
    else $error("hold mode activity wrong");
  drv_gate_a: assert property (clock_output_driver |-> clock_output_enable)
    else $error("clock driver on without enable bit");
  cover property (mode == transmit_with_pa_state);
  cover property (mode == TXCFG_RESET_REG);
  cover property (mode == TXCFG_CLK_ONLY && clock_output_driver);
endmodule // txcfg_link_checker
`default_nettype wire

// file: txcfg_link_if.sv
// Three-wire serial link between host controller and transmitter
`timescale 1ns/1ns
`default_nettype none
interface txcfg_link_if;
  logic enable;
  logic sclk;
  logic serial_data_modulation_in;
  modport host (output enable, output sclk, output serial_data_modulation_in);
  modport dev (input enable, input sclk, input serial_data_modulation_in);
endinterface // txcfg_link_if
`default_nettype wire

// file: txcfg_pkg.sv
// Shared constants and types for the transmitter serial configuration link
`default_nettype none
package txcfg_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCK_HALF_NS = 250;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_MIN_NS = 10000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XTO_START_DEF = 16;
  localparam int PLL_LOCK_DEF = 8;
  // ----------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------
  localparam int CFG_BITS = 32;
  localparam logic [5:0] CFG_BITS_CNT = 6'h20;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam int BIT_CLK_ONLY = 31;
  localparam int BIT_VCO_BAND = 30;
  localparam int CARRIER_FREQUENCY_WORD_LSB = 15;
  localparam int CARRIER_FREQUENCY_WORD_W = 15;
  localparam int FSK_DEVIATION_WORD_LSB = 7;
  localparam int FSK_DEVIATION_WORD_W = 8;
  localparam int BIT_DIV_SEL = 6;
  localparam int PWR_LSB = 2;
  localparam int PWR_W = 4;
  localparam int BIT_MOD_SEL = 1;
  localparam int BIT_CLK_ON = 0;
  // ----------------------------------------------------------------
  // Host command registers
  // ----------------------------------------------------------------
  localparam logic [3:0] HREG_CFG = 4'h0;
  localparam logic [3:0] HREG_CTRL = 4'h4;
  localparam logic [3:0] HREG_STATUS = 4'h8;
  localparam int CTRL_PROGRAM = 0;
  localparam int CTRL_POWER_DOWN = 1;
  localparam int CTRL_REPROGRAM = 2;
  localparam int CTRL_TX_DATA = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_PROGRAMMED = 1;
  localparam int STAT_TX_DATA = 3;
  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TXCFG_OFF, TXCFG_STARTUP1, TXCFG_STARTUP2, TXCFG_TX1, transmit_with_pa_state,
    TXCFG_CLK_ONLY, TXCFG_RESET_REG, TXCFG_CONFIG1, TXCFG_CONFIG2
  } txcfg_mode_t;
  typedef enum logic [2:0] {
    TXCFG_H_OFF, TXCFG_H_LEAD, TXCFG_H_SHIFT_LO, TXCFG_H_SHIFT_HI,
    TXCFG_H_XMIT, TXCFG_H_RH_HOLD, TXCFG_H_RH_EN
  } txcfg_hstate_t;
endpackage
`default_nettype wire
